/* File: hw/coll_page_pkg.sv */
// shared offsets, field positions, reset values and constants for the collision/page/mode slice
package coll_page_pkg;
    // register offsets (6-bit register address space)
    localparam logic [5:0] COLLISION_REPORT_ADDR      = 6'h0e;
    localparam logic [5:0] REGISTER_PAGE_CONTROL_ADDR = 6'h10;
    localparam logic [5:0] GENERAL_MODE_SETTINGS_ADDR = 6'h11;

    // collision_report fields
    localparam int KEEP_BITS_BIT   = 7;
    localparam int POS_INVALID_BIT = 5;
    localparam int POS_MSB         = 4;
    localparam logic [2:0] COLLISION_REPORT_TOP_RESET = 3'h5; // binary 101
    localparam logic [4:0] COLLISION_POS_RESET        = 5'h00; // undefined in hardware

    // register_page_control fields
    localparam int PAGE_OVERRIDE_BIT = 7;
    localparam logic [7:0] REGISTER_PAGE_CONTROL_RESET = 8'h00;

    // general_mode_settings fields
    localparam int CRC_BIT_ORDER_BIT   = 7;
    localparam int DETECT_SYNC_BIT     = 6;
    localparam int TX_NEEDS_FIELD_BIT  = 5;
    localparam int RX_NEEDS_FIELD_BIT  = 4;
    localparam int ENV_POLARITY_BIT    = 3;
    localparam int DETECTOR_OFF_BIT    = 2;
    localparam logic [7:0] GENERAL_MODE_SETTINGS_RESET = 8'h3b;

    // crc start values
    localparam logic [15:0] CRC_START_00 = 16'h0000;
    localparam logic [15:0] CRC_START_01 = 16'h6363;
    localparam logic [15:0] CRC_START_10 = 16'ha671;
    localparam logic [15:0] CRC_START_11 = 16'hffff;

    // largest one-based position the field can carry (0 stands for 32)
    localparam logic [6:0] MAX_COLLISION_POS = 7'd32;
endpackage : coll_page_pkg

/* File: hw/bit_sync.sv */
// two flip-flop synchroniser for one level from a pin
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;
    logic sync_r;

    // first stage is only read by the second
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : bit_sync
`default_nettype wire

/* File: hw/collision_tracker.sv */
// tracks the first collision of a frame and masks received bits after it
`timescale 1ns/1ps
`default_nettype none
module collision_tracker
    import coll_page_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_frame_start,
    input  wire logic       i_rx_bit_valid,
    input  wire logic       i_rx_bit,
    input  wire logic       i_rx_bit_is_data,
    input  wire logic       i_rx_collision,
    input  wire logic       i_keep_bits,
    output logic            o_rx_bit_valid,
    output logic            o_rx_bit,
    output logic            o_seen,
    output logic [6:0]      o_first_pos
);
    logic [6:0] count_r;
    logic       seen_r;
    logic [6:0] first_r;
    logic       out_valid_r;
    logic       out_bit_r;
    wire  [6:0] count_inc  = (count_r == 7'h7f) ? count_r : 7'(count_r + 7'd1);
    wire        data_bit   = i_rx_bit_valid && i_rx_bit_is_data;
    wire        new_coll   = data_bit && i_rx_collision && !seen_r;
    // bits after a collision are forced to zero unless kept
    wire        kill_bit   = seen_r && !i_keep_bits;

    // count data bits only; capture first collision position, one-based
    always_ff @(posedge i_clk) begin
        if (i_reset || i_frame_start) begin
            count_r <= 7'd0;
            seen_r  <= 1'b0;
            first_r <= 7'd0;
        end else if (data_bit) begin
            count_r <= count_inc;
            if (new_coll) begin
                seen_r  <= 1'b1;
                first_r <= count_inc;
            end
        end
    end

    // registered bit stream toward the receive path
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            out_valid_r <= 1'b0;
            out_bit_r   <= 1'b0;
        end else begin
            out_valid_r <= i_rx_bit_valid;
            out_bit_r   <= i_rx_bit && !kill_bit;
        end
    end

    assign o_rx_bit_valid = out_valid_r;
    assign o_rx_bit       = out_bit_r;
    assign o_seen         = seen_r;
    assign o_first_pos    = first_r;
endmodule : collision_tracker
`default_nettype wire

/* File: hw/collision_page_mode_regs.sv */
// collision report, page select and general mode registers of the transceiver control logic
// What this block does
// - keep bit zero clears bits after collision
// - invalid flag set: no collision or out-of-range
// - five-bit field holds first collision position
// - positions one-based; zero means bit 32
// - override on takes A5..A4 from page number
// - override off uses full latched address
// - page number bits 1..0, used only if enabled
// - collision register upper bits reset to 101
// - crc start field selects 0000/6363/a671/ffff
// - polarity bit makes envelope pin active high
`timescale 1ns/1ps
`default_nettype none
module collision_page_mode_regs (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // register port
    input  wire logic [5:0]  i_addr_latch,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    output logic      [5:0]  o_reg_addr,
    // receive path
    input  wire logic        i_frame_start,
    input  wire logic        i_frame_end,
    input  wire logic        i_rx_bit_valid,
    input  wire logic        i_rx_bit,
    input  wire logic        i_rx_bit_is_data,
    input  wire logic        i_rx_collision,
    output logic             o_rx_bit_valid,
    output logic             o_rx_bit,
    // envelope pin and mode outputs
    input  wire logic        i_envelope_input_pin,
    output logic             o_envelope_active,
    output logic [15:0]      o_crc_start_value,
    output logic             o_crc_reversed_bit_order,
    output logic             o_detect_sync,
    output logic             o_transmit_needs_field,
    output logic             o_receive_wait_needs_field,
    output logic             o_protocol_detector_disable
);
    import coll_page_pkg::*;

    logic       keep_bits_after_collision_r;
    logic       collision_position_invalid_r;
    logic [4:0] first_collision_index_r;
    logic       page_override_enable_r;
    logic [1:0] register_page_number_r;
    logic [7:0] general_mode_settings_r;
    logic [7:0] rdata_r;
    logic       envelope_r;

    logic       coll_seen;
    logic [6:0] coll_first_pos;
    logic       env_sync;

    // crc start lookup, shared by any caller needing the preset word
    function automatic logic [15:0] crc_start_of(input logic [1:0] sel);
        logic [15:0] v;
        v = CRC_START_00;
        case (sel)
            2'h0: v = CRC_START_00;
            2'h1: v = CRC_START_01;
            2'h2: v = CRC_START_10;
            default: v = CRC_START_11;
        endcase
        return v;
    endfunction : crc_start_of

    // register address formation from latch and page override
    wire [5:0] eff_addr = page_override_enable_r
                        ? {register_page_number_r, i_addr_latch[3:0]}
                        : i_addr_latch;
    assign o_reg_addr = eff_addr;

    // address decode
    wire sel_coll = (eff_addr == COLLISION_REPORT_ADDR);
    wire sel_page = (eff_addr == REGISTER_PAGE_CONTROL_ADDR);
    wire sel_mode = (eff_addr == GENERAL_MODE_SETTINGS_ADDR);

    // register images, reserved bits forced to zero
    wire [7:0] coll_image = {keep_bits_after_collision_r, 1'b0,
                             collision_position_invalid_r,
                             first_collision_index_r};
    wire [7:0] page_image = {page_override_enable_r, 5'h00,
                             register_page_number_r};
    wire [7:0] read_mux   = sel_coll ? coll_image
                          : sel_page ? page_image
                          : sel_mode ? general_mode_settings_r
                          : 8'h00;

    // position beyond 32 or no collision at all marks the report invalid
    wire frame_invalid = !coll_seen || (coll_first_pos > MAX_COLLISION_POS);
    // 32 wraps to zero in the five-bit field
    wire [4:0] frame_pos = coll_first_pos[4:0];

    collision_tracker u_tracker (
        .i_clk            (i_clk),
        .i_reset          (i_reset),
        .i_frame_start    (i_frame_start),
        .i_rx_bit_valid   (i_rx_bit_valid),
        .i_rx_bit         (i_rx_bit),
        .i_rx_bit_is_data (i_rx_bit_is_data),
        .i_rx_collision   (i_rx_collision),
        .i_keep_bits      (keep_bits_after_collision_r),
        .o_rx_bit_valid   (o_rx_bit_valid),
        .o_rx_bit         (o_rx_bit),
        .o_seen           (coll_seen),
        .o_first_pos      (coll_first_pos)
    );

    // envelope pin comes from outside, so synchronise before use
    bit_sync u_env_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_envelope_input_pin),
        .o_sync  (env_sync)
    );

    // collision register: software writes bit 7, hardware updates status at frame end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            keep_bits_after_collision_r  <= COLLISION_REPORT_TOP_RESET[2];
            collision_position_invalid_r <= COLLISION_REPORT_TOP_RESET[0];
            first_collision_index_r      <= COLLISION_POS_RESET;
        end else begin
            if (i_wr && sel_coll) begin
                keep_bits_after_collision_r <= i_wdata[KEEP_BITS_BIT];
            end
            if (i_frame_end) begin
                collision_position_invalid_r <= frame_invalid;
                first_collision_index_r      <= frame_pos;
            end
        end
    end

    // page control register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            page_override_enable_r <= REGISTER_PAGE_CONTROL_RESET[PAGE_OVERRIDE_BIT];
            register_page_number_r <= REGISTER_PAGE_CONTROL_RESET[1:0];
        end else if (i_wr && sel_page) begin
            page_override_enable_r <= i_wdata[PAGE_OVERRIDE_BIT];
            register_page_number_r <= i_wdata[1:0];
        end
    end

    // general mode register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            general_mode_settings_r <= GENERAL_MODE_SETTINGS_RESET;
        end else if (i_wr && sel_mode) begin
            general_mode_settings_r <= i_wdata;
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= i_rd ? read_mux : 8'h00;
        end
    end
    assign o_rdata = rdata_r;

    // internal envelope is active high; polarity bit says how the pin is read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            envelope_r <= 1'b0;
        end else begin
            envelope_r <= general_mode_settings_r[ENV_POLARITY_BIT] ? env_sync : !env_sync;
        end
    end
    assign o_envelope_active = envelope_r;

    // mode fields out to the rest of the device
    assign o_crc_start_value           = crc_start_of(general_mode_settings_r[1:0]);
    assign o_crc_reversed_bit_order    = general_mode_settings_r[CRC_BIT_ORDER_BIT];
    assign o_detect_sync               = general_mode_settings_r[DETECT_SYNC_BIT];
    assign o_transmit_needs_field      = general_mode_settings_r[TX_NEEDS_FIELD_BIT];
    assign o_receive_wait_needs_field  = general_mode_settings_r[RX_NEEDS_FIELD_BIT];
    assign o_protocol_detector_disable = general_mode_settings_r[DETECTOR_OFF_BIT];
endmodule : collision_page_mode_regs
`default_nettype wire

/* File: bench/collision_page_mode_regs_chk.sv */
// concurrent checks on the ports of the collision/page/mode register slice
`timescale 1ns/1ps
`default_nettype none
module collision_page_mode_regs_chk (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [5:0]  i_addr_latch,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic [5:0]  o_reg_addr,
    input wire logic        i_frame_start,
    input wire logic        i_frame_end,
    input wire logic        i_rx_bit_valid,
    input wire logic        i_rx_bit,
    input wire logic        i_rx_collision,
    input wire logic        o_rx_bit_valid,
    input wire logic        o_rx_bit,
    input wire logic [15:0] o_crc_start_value
);
    import coll_page_pkg::*;
    // shadows follow the effective address, so page override mistakes show up twice
    logic [7:0] page_r;
    logic [1:0] crc_r;
    logic       keep_r, seen_r, framed_r;
    wire        rd_coll = i_rd && (o_reg_addr == COLLISION_REPORT_ADDR);
    wire        rd_page = i_rd && (o_reg_addr == REGISTER_PAGE_CONTROL_ADDR);
    wire        wr_page = i_wr && (o_reg_addr == REGISTER_PAGE_CONTROL_ADDR);
    wire        wr_coll = i_wr && (o_reg_addr == COLLISION_REPORT_ADDR);
    wire        wr_mode = i_wr && (o_reg_addr == GENERAL_MODE_SETTINGS_ADDR);
    // helper state, reset to the documented values
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            page_r <= 8'h00;
            crc_r <= 2'h3;
            keep_r <= 1'b1;
            seen_r <= 1'b0;
            framed_r <= 1'b0;
        end else begin
            if (wr_page) page_r <= i_wdata & 8'h83;
            if (wr_mode) crc_r <= i_wdata[1:0];
            if (wr_coll) keep_r <= i_wdata[7];
            seen_r <= !i_frame_start && (seen_r || (i_rx_bit_valid && i_rx_collision));
            framed_r <= framed_r || i_frame_end;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_page_on_addr: assert property (page_r[7] |->
        o_reg_addr == {page_r[1:0], i_addr_latch[3:0]}) else $error("page override address wrong");
    a_page_off_addr: assert property (!page_r[7] |->
        o_reg_addr == i_addr_latch) else $error("latched address not used");
    a_page_read_back: assert property (rd_page |=> o_rdata == page_r)
        else $error("page register read back wrong");
    a_coll_resv_zero: assert property (rd_coll |=> o_rdata[7:6] == {keep_r, 1'b0})
        else $error("collision register top bits wrong");
    a_coll_reset_top: assert property (rd_coll && !framed_r |=> o_rdata[5])
        else $error("invalid flag clear before any frame");
    a_keep_pass_bits: assert property (i_rx_bit_valid && (keep_r || !seen_r) |=>
        o_rx_bit_valid && o_rx_bit == $past(i_rx_bit)) else $error("received bit not passed");
    a_clear_after_coll: assert property (i_rx_bit_valid && !keep_r && seen_r |=>
        o_rx_bit_valid && !o_rx_bit) else $error("bit after collision not cleared");
    a_crc_start_map: assert property (o_crc_start_value == (crc_r[1] ?
        (crc_r[0] ? 16'hffff : 16'ha671) : (crc_r[0] ? 16'h6363 : 16'h0000)))
        else $error("crc start value wrong");
endmodule : collision_page_mode_regs_chk
bind collision_page_mode_regs collision_page_mode_regs_chk u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr_latch(i_addr_latch), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_reg_addr(o_reg_addr),
    .i_frame_start(i_frame_start), .i_frame_end(i_frame_end), .i_rx_bit_valid(i_rx_bit_valid),
    .i_rx_bit(i_rx_bit), .i_rx_collision(i_rx_collision), .o_rx_bit_valid(o_rx_bit_valid),
    .o_rx_bit(o_rx_bit), .o_crc_start_value(o_crc_start_value));
`default_nettype wire

/* File: bench/test_collision_page_mode_regs.sv */
// self-checking bench for the collision/page/mode register slice
`timescale 1ns/1ps
`default_nettype none
module test_collision_page_mode_regs;
    import coll_page_pkg::*;
    logic        i_clk, i_reset, i_wr, i_rd, i_frame_start, i_frame_end, i_rx_bit_valid;
    logic        i_rx_bit, i_rx_bit_is_data, i_rx_collision, i_envelope_input_pin;
    logic [5:0]  i_addr_latch, o_reg_addr;
    logic [7:0]  i_wdata, o_rdata, v;
    logic [15:0] o_crc_start_value, e;
    logic        o_rx_bit_valid, o_rx_bit, o_envelope_active, o_crc_reversed_bit_order;
    logic        o_detect_sync, o_transmit_needs_field, o_receive_wait_needs_field;
    logic        o_protocol_detector_disable, rd_d;
    logic [15:0] rq[$];
    logic        bq[$];
    int          num_errors, compares;
    logic [15:0] crc_tab [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    collision_page_mode_regs u_collision_page_mode_regs (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr_latch(i_addr_latch), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_reg_addr(o_reg_addr),
        .i_frame_start(i_frame_start), .i_frame_end(i_frame_end), .i_rx_bit(i_rx_bit),
        .i_rx_bit_valid(i_rx_bit_valid), .i_rx_bit_is_data(i_rx_bit_is_data),
        .i_rx_collision(i_rx_collision), .o_rx_bit_valid(o_rx_bit_valid), .o_rx_bit(o_rx_bit),
        .i_envelope_input_pin(i_envelope_input_pin), .o_envelope_active(o_envelope_active),
        .o_crc_start_value(o_crc_start_value), .o_detect_sync(o_detect_sync),
        .o_crc_reversed_bit_order(o_crc_reversed_bit_order),
        .o_transmit_needs_field(o_transmit_needs_field),
        .o_receive_wait_needs_field(o_receive_wait_needs_field),
        .o_protocol_detector_disable(o_protocol_detector_disable));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [15:0] x, g, m);
        compares++;
        if ((g & m) !== (x & m)) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, x & m, g & m);
        end
    endtask : chk
    // every call drives all register strobes once, then lets the sampling edge pass
    task automatic op(input logic w, r, input logic [5:0] a, input logic [7:0] d);
        {i_wr, i_rd, i_addr_latch, i_wdata} <= {w, r, a, d};
        @(posedge i_clk);
    endtask : op
    task automatic rd(input logic [5:0] a, input logic [7:0] x, m);
        rq.push_back({m, x});
        op(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic rxs(input logic [5:0] s); // start, end, valid, bit, data, collision
        {i_frame_start, i_frame_end, i_rx_bit_valid, i_rx_bit, i_rx_bit_is_data, i_rx_collision} <= s;
        @(posedge i_clk);
    endtask : rxs
    // one frame: a framing bit, n data bits, first collision at ci (0 = none), a later one too
    task automatic frame(input int n, ci, input logic k, input logic [7:0] x, m);
        logic b;
        op(1'b1, 1'b0, COLLISION_REPORT_ADDR, {k, 7'h00});
        op(1'b0, 1'b0, COLLISION_REPORT_ADDR, 8'h00);
        rxs(6'b100000);
        bq.push_back(1'b1);
        rxs(6'b001100);
        for (int i = 1; i <= n; i++) begin
            b = 1'($urandom);
            bq.push_back(b & (k || ci == 0 || i <= ci));
            rxs({3'b001, b, 1'b1, (i == ci) || (ci != 0 && i == n)});
        end
        rxs(6'b010000);
        rxs(6'b000000);
        rd(COLLISION_REPORT_ADDR, x, m);
        op(1'b0, 1'b0, COLLISION_REPORT_ADDR, 8'h00);
    endtask : frame
    // results are compared half a cycle after they appear, oldest note first
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) begin
        if (rd_d !== 1'b0) begin
            e = (rq.size() != 0) ? rq.pop_front() : 16'hffff;
            chk("rdata", {8'h00, e[7:0]}, {8'h00, o_rdata}, {8'h00, e[15:8]});
        end
        if (o_rx_bit_valid !== 1'b0) begin
            // an empty queue expects an impossible word, so a stray bit always fails
            e = (bq.size() != 0) ? {15'h0, bq.pop_front()} : 16'hffff;
            chk("rx_bit", e, {15'h0, o_rx_bit}, 16'hffff);
        end
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        {i_reset, i_wr, i_rd, i_frame_start, i_frame_end, i_rx_bit_valid} = 6'b100000;
        {i_rx_bit, i_rx_bit_is_data, i_rx_collision, i_envelope_input_pin} = 4'h0;
        {i_addr_latch, i_wdata, num_errors, compares} = '0;
        void'($urandom(32'h8b61));
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(6'h0e, 8'ha0, 8'he0);
        rd(6'h10, 8'h00, 8'hff);
        rd(6'h11, 8'h3b, 8'hff);
        op(1'b1, 1'b0, 6'h10, 8'h7c);
        rd(6'h10, 8'h00, 8'hff);
        op(1'b1, 1'b0, 6'h0e, 8'h5f);
        rd(6'h0e, 8'h20, 8'he0);
        op(1'b1, 1'b0, 6'h10, 8'h81);
        op(1'b0, 1'b0, 6'h21, 8'h00);
        chk("reg_addr", 16'h0011, {10'h0, o_reg_addr}, 16'h003f);
        rd(6'h01, 8'h3b, 8'hff);
        rd(6'h30, 8'h81, 8'hff);
        op(1'b1, 1'b0, 6'h00, 8'h02);
        rd(6'h11, 8'h3b, 8'hff);
        rd(6'h10, 8'h02, 8'hff);
        rd(6'h3f, 8'h00, 8'hff);
        for (int k = 0; k < 4; k++) begin
            v = {6'($urandom), 2'(k)};
            op(1'b1, 1'b0, 6'h11, v);
            rd(6'h11, v, 8'hff);
            chk("crc_start", crc_tab[k], o_crc_start_value, 16'hffff);
            chk("mode_bits", {11'h0, v[7:4], v[2]}, {11'h0, o_crc_reversed_bit_order,
                o_detect_sync, o_transmit_needs_field, o_receive_wait_needs_field,
                o_protocol_detector_disable}, 16'h001f);
        end
        for (int p = 0; p < 4; p++) begin
            i_envelope_input_pin <= p[0];
            op(1'b1, 1'b0, 6'h11, {4'h3, p[1], 3'h3});
            repeat (4) op(1'b0, 1'b0, 6'h11, 8'h00);
            chk("envelope", {15'h0, ~(p[0] ^ p[1])}, {15'h0, o_envelope_active}, 16'h1);
        end
        frame(10, 3, 1'b0, 8'h03, 8'hff);
        frame(4, 1, 1'b0, 8'h01, 8'hff);
        frame(12, 8, 1'b1, 8'h88, 8'hff);
        frame(40, 32, 1'b1, 8'h80, 8'hff);
        frame(40, 33, 1'b0, 8'h21, 8'hff);
        frame(5, 0, 1'b1, 8'ha0, 8'he0);
        repeat (3) @(posedge i_clk);
        if (rq.size() + bq.size() != 0) begin
            num_errors++;
            $display("[FAIL] pending_notes expected 0 seen %0d", rq.size() + bq.size());
        end
        wrap_up();
    end
endmodule : test_collision_page_mode_regs
`default_nettype wire
